//--- rtl/fpc_pkg.sv
// Purpose: shared types and constants for the fourth-data-line pin control
// Assumes: status bits arrive as plain inputs from the device core
// Notes:   one clock domain, sys_clk at 25 MHz
package fpc_pkg;
   typedef enum logic [2:0] {
      FPC_IDLE, FPC_SGL_WR, FPC_SGL_RD, FPC_QUAD_PROG, FPC_QUAD_READ
   } fpc_mode_t;

   // index of the pause-or-reset select bit in the third status register
   localparam int         SR3_SEL_BIT   = 7;
   localparam logic       SEL_RESET     = 1'b1;
   localparam logic [3:0] IO_ALL        = 4'hF;
   localparam logic [3:0] IO_NONE       = 4'h0;
   localparam logic [3:0] IO_SO_ONLY    = 4'h2;
   localparam logic [2:0] BIT_CNT_RST   = 3'h0;
   // length of an internally timed program or erase cycle, in sys_clk cycles
   localparam logic [11:0] TIMED_CYCLES = 12'h100;
endpackage : fpc_pkg

//--- rtl/fpc_lane_if.sv
// Purpose: synchronised serial-pin view passed from the pin sampler to the core
// Assumes: all members are in the sys_clk domain
// Notes:   edges are one-cycle pulses
`timescale 1ns/10ps
interface fpc_lane_if;
   logic       cs_n;
   logic       sck_lvl;
   logic       sck_rise;
   logic       sck_fall;
   logic [3:0] io;
   modport src (output cs_n, sck_lvl, sck_rise, sck_fall, io);
   modport dst (input  cs_n, sck_lvl, sck_rise, sck_fall, io);
endinterface : fpc_lane_if

//--- rtl/fpc_pin_sync.sv
// Purpose: two-flop synchronisers for the serial pins and serial clock edge finding
// Assumes: serial clock well below half of sys_clk
// Notes:   edge detection reads only the second stage
`timescale 1ns/10ps
module fpc_pin_sync
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // pins
   input  wire logic       cs_n_pin,
   input  wire logic       sck_pin,
   input  wire logic [3:0] io_pin,
   // synchronised view
   fpc_lane_if.src         lane
);
   logic [5:0] meta_ff,  nxt_meta;
   logic [5:0] sync_ff,  nxt_sync;
   logic       sck_d_ff, nxt_sck_d;

   always_comb begin
      nxt_meta  = {cs_n_pin, sck_pin, io_pin};
      nxt_sync  = meta_ff;
      nxt_sck_d = sync_ff[4];
   end

   // reset to the idle pin levels (deselected, clock low, io3/io2 pulled high)
   // so no false clock edge or pause is seen when reset lets go
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_ff  <= 6'h2C;
         sync_ff  <= 6'h2C;
         sck_d_ff <= 1'b0;
      end else begin
         meta_ff  <= nxt_meta;
         sync_ff  <= nxt_sync;
         sck_d_ff <= nxt_sck_d;
      end
   end

   assign lane.cs_n     = sync_ff[5];
   assign lane.sck_lvl  = sync_ff[4];
   assign lane.io       = sync_ff[3:0];
   assign lane.sck_rise = sync_ff[4] & ~sck_d_ff;
   assign lane.sck_fall = ~sync_ff[4] & sck_d_ff;
endmodule // fpc_pin_sync

//--- rtl/fpc_top.sv
// Purpose: pause / reset / fourth data line control behind the serial pins
// Assumes: command decode in the core supplies the transfer mode
// Notes:   pins are sampled, so serial clock must stay under sys_clk / 4
`timescale 1ns/10ps

// Functional notes
// - pause low: ignore clock and input data, output lines go high impedance
// - pause keeps selection and transfer state; transfer resumes on release
// - pause never stops or changes a running timed program or erase cycle
// - quad program: pin is fourth input, four bits taken per rising edge
// - quad read: pin is fourth output, four bits driven per falling edge
// - quad enable clear: status3 bit 7 picks pause or reset role
// - quad enable set: pause and reset disabled, pin only carries data
// - quad enable makes the write-protect pin the third data line
// - latch inputs on rising edges, shift outputs on falling edges
module fpc_top import fpc_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // serial pins
   input  wire logic       cs_n_pin,
   input  wire logic       sck_pin,
   input  wire logic [3:0] io_in,
   output logic      [3:0] io_out,
   output logic      [3:0] io_oe,
   // configuration from status registers
   input  wire logic       quad_enable_bit,
   input  wire logic [7:0] status3,
   // core side
   input  wire fpc_mode_t  xfer_mode,
   input  wire logic [3:0] tx_bits,
   input  wire logic       timed_start,
   output logic      [3:0] rx_data,
   output logic            rx_valid,
   output logic            tx_req,
   output logic            paused,
   output logic            pin_reset,
   output logic            timed_busy
);
   fpc_lane_if lane ();

   fpc_pin_sync u_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .cs_n_pin (cs_n_pin),
      .sck_pin  (sck_pin),
      .io_pin   (io_in),
      .lane     (lane.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   logic        paused_ff,     nxt_paused;
   logic        pin_reset_ff,  nxt_pin_reset;
   logic [3:0]  rx_data_ff,    nxt_rx_data;
   logic        rx_valid_ff,   nxt_rx_valid;
   logic        tx_req_ff,     nxt_tx_req;
   logic [3:0]  io_out_ff,     nxt_io_out;
   logic [3:0]  io_oe_ff,      nxt_io_oe;
   logic [2:0]  bit_cnt_ff,    nxt_bit_cnt;
   logic        timed_busy_ff, nxt_timed_busy;
   logic [11:0] timed_cnt_ff,  nxt_timed_cnt;
   logic        role_pause;
   logic        role_reset;
   logic        selected;
   logic        quad_mode;

   always_comb begin
      // pin roles exist only with quad enable clear
      role_pause = ~quad_enable_bit & (status3[SR3_SEL_BIT] != SEL_RESET);
      role_reset = ~quad_enable_bit & (status3[SR3_SEL_BIT] == SEL_RESET);
      nxt_pin_reset = role_reset & ~lane.io[3];
      selected   = ~lane.cs_n & ~nxt_pin_reset;
      quad_mode  = quad_enable_bit &
                   (xfer_mode == FPC_QUAD_PROG || xfer_mode == FPC_QUAD_READ);

      // a pause only begins with the clock low; once in, it holds until release
      nxt_paused = role_pause & ~lane.io[3] & ~lane.cs_n &
                   (paused_ff | ~lane.sck_lvl);

      nxt_rx_data  = rx_data_ff;
      nxt_rx_valid = 1'b0;
      nxt_tx_req   = 1'b0;
      nxt_io_out   = io_out_ff;
      nxt_bit_cnt  = bit_cnt_ff;

      if (!selected) begin
         nxt_bit_cnt = BIT_CNT_RST;
      end else if (!nxt_paused) begin
         // while paused, counters and shift data simply hold
         if (lane.sck_rise) begin
            nxt_rx_valid = (xfer_mode != FPC_IDLE);
            if (quad_mode && xfer_mode == FPC_QUAD_PROG) begin
               nxt_rx_data = lane.io;
               nxt_bit_cnt = bit_cnt_ff + 3'h4;
            end else begin
               nxt_rx_data = {3'h0, lane.io[0]};
               nxt_bit_cnt = bit_cnt_ff + 3'h1;
            end
         end
         if (lane.sck_fall &&
             (xfer_mode == FPC_SGL_RD || (quad_mode && xfer_mode == FPC_QUAD_READ))) begin
            nxt_io_out = tx_bits;
            nxt_tx_req = 1'b1;
         end
      end

      if (!selected || nxt_paused) begin
         nxt_io_oe = IO_NONE;
      end else if (quad_mode && xfer_mode == FPC_QUAD_READ) begin
         nxt_io_oe = IO_ALL;
      end else if (xfer_mode == FPC_SGL_RD) begin
         nxt_io_oe = IO_SO_ONLY;
      end else begin
         nxt_io_oe = IO_NONE;
      end

      // timed cycle counts on sys_clk only; pause and pins cannot touch it
      nxt_timed_busy = timed_busy_ff;
      nxt_timed_cnt  = timed_cnt_ff;
      if (timed_busy_ff) begin
         nxt_timed_cnt = timed_cnt_ff - 12'h001;
         if (timed_cnt_ff == 12'h001) begin
            nxt_timed_busy = 1'b0;
         end
      end else if (timed_start) begin
         nxt_timed_busy = 1'b1;
         nxt_timed_cnt  = TIMED_CYCLES;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         paused_ff     <= 1'b0;
         pin_reset_ff  <= 1'b0;
         rx_data_ff    <= 4'h0;
         rx_valid_ff   <= 1'b0;
         tx_req_ff     <= 1'b0;
         io_out_ff     <= 4'h0;
         io_oe_ff      <= IO_NONE;
         bit_cnt_ff    <= BIT_CNT_RST;
         timed_busy_ff <= 1'b0;
         timed_cnt_ff  <= 12'h000;
      end else begin
         paused_ff     <= nxt_paused;
         pin_reset_ff  <= nxt_pin_reset;
         rx_data_ff    <= nxt_rx_data;
         rx_valid_ff   <= nxt_rx_valid;
         tx_req_ff     <= nxt_tx_req;
         io_out_ff     <= nxt_io_out;
         io_oe_ff      <= nxt_io_oe;
         bit_cnt_ff    <= nxt_bit_cnt;
         timed_busy_ff <= nxt_timed_busy;
         timed_cnt_ff  <= nxt_timed_cnt;
      end
   end

   assign io_out     = io_out_ff;
   assign io_oe      = io_oe_ff;
   assign rx_data    = rx_data_ff;
   assign rx_valid   = rx_valid_ff;
   assign tx_req     = tx_req_ff;
   assign paused     = paused_ff;
   assign pin_reset  = pin_reset_ff;
   assign timed_busy = timed_busy_ff;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_pause_hiz_out: assert property (paused_ff |-> io_oe_ff == IO_NONE)
      else $error("outputs driven during pause");
   chk_pause_no_rx: assert property (rx_valid_ff |-> !paused_ff)
      else $error("data taken during pause");
   chk_pause_start_ok: assert property ($rose(paused_ff) |->
      $past(!lane.cs_n && !lane.sck_lvl))
      else $error("pause began with clock high or deselected");
   chk_pause_holds_cnt: assert property (paused_ff && $past(paused_ff) |->
      bit_cnt_ff == $past(bit_cnt_ff))
      else $error("transfer state moved during pause");
   chk_timed_runs_on: assert property (timed_busy_ff && timed_cnt_ff > 12'h001 |=>
      timed_busy_ff && timed_cnt_ff == $past(timed_cnt_ff) - 12'h001)
      else $error("timed cycle disturbed");
   chk_quad_rx_take: assert property (rx_valid_ff && xfer_mode == FPC_QUAD_PROG &&
      quad_enable_bit && $stable(xfer_mode) |-> rx_data_ff == $past(lane.io))
      else $error("quad input nibble wrong");
   chk_quad_rd_drive: assert property (io_oe_ff == IO_ALL |->
      $past(xfer_mode == FPC_QUAD_READ && quad_enable_bit))
      else $error("four lanes driven outside quad read");
   chk_role_reset_sel: assert property (pin_reset_ff |->
      $past(status3[SR3_SEL_BIT] == SEL_RESET && !quad_enable_bit))
      else $error("reset role without select bit");
   chk_qe_no_pause: assert property (quad_enable_bit |=> !paused_ff && !pin_reset_ff)
      else $error("pause or reset active with quad enable");
   chk_wp_lane_qe: assert property (io_oe_ff[2] |-> $past(quad_enable_bit))
      else $error("third data line driven without quad enable");
   chk_tx_on_fall: assert property ($changed(io_out_ff) |-> $past(lane.sck_fall))
      else $error("output changed off a falling edge");
   chk_rx_on_rise: assert property (rx_valid_ff |-> $past(lane.sck_rise))
      else $error("input taken off a rising edge");
endmodule // fpc_top

//--- verification/fpc_spi_host.sv
// Purpose: behavioural serial host that drives the pins of the fourth-data-line control
// Assumes: serial clock period 320 ns, clock idles low between pulses
// Notes:   released lines: io3/io2 pulled high, io1/io0 show the inverse of the last value
`timescale 1ns/10ps
module fpc_spi_host
(
   // serial pins
   output logic       cs_n,
   output logic       sck,
   output logic [3:0] io
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      io   = 4'hC;
   end
   // odd offset keeps pin edges away from sys_clk edges
   task automatic sel(input logic low);
      #7;
      cs_n = ~low;
      #153;
   endtask
   // lines change only while sck is low, so a pause always starts legally
   task automatic drive(input logic [3:0] d, input logic [3:0] en);
      io = (d & en) | (~en & {2'b11, ~io[1:0]});
      #160;
   endtask
   task automatic pulse();
      sck = 1'b1;
      #160;
      sck = 1'b0;
      #160;
   endtask
endmodule // fpc_spi_host

//--- verification/fpc_top_tb.sv
// Purpose: self-checking bench for the fourth-data-line pin control
// Assumes: host model supplies the pins, bench drives the core side at negedge
// Notes:   pulses are counted on every sys_clk rising edge
`timescale 1ns/10ps
module fpc_top_tb;
   import fpc_pkg::*;
   logic        sys_clk = 1'b0;
   logic        sys_rst;
   logic        cs_n_pin, sck_pin, quad_enable_bit, timed_start;
   logic [3:0]  h_io, io_in, io_out, io_oe, rx_data, tx_bits, last_rx;
   logic [7:0]  status3, last_tx;
   fpc_mode_t   xfer_mode;
   logic        rx_valid, tx_req, paused, pin_reset, timed_busy;
   logic [11:0] n_rx = '0, n_tx = '0, n_busy = '0, n0, miscompares = '0, n_checks = '0;
   logic [3:0]  nib [2] = '{4'h5, 4'hA};

   always #20 sys_clk = ~sys_clk;
   assign io_in = (io_oe & io_out) | (~io_oe & h_io);

   fpc_spi_host h (.cs_n(cs_n_pin), .sck(sck_pin), .io(h_io));
   fpc_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_enable_bit),
      .status3(status3), .xfer_mode(xfer_mode), .tx_bits(tx_bits),
      .timed_start(timed_start), .rx_data(rx_data), .rx_valid(rx_valid), .tx_req(tx_req),
      .paused(paused), .pin_reset(pin_reset), .timed_busy(timed_busy));

   always @(posedge sys_clk) begin
      if (rx_valid === 1'b1) begin
         n_rx++;
         last_rx = rx_data;
      end
      if (tx_req === 1'b1) begin
         n_tx++;
         last_tx = {io_oe, io_out};
      end
      if (timed_busy === 1'b1) n_busy++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   task automatic wait_cy(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic cfg(input logic q, input logic [7:0] s, input fpc_mode_t m,
                      input logic [3:0] t);
      @(negedge sys_clk);
      quad_enable_bit = q;
      status3 = s;
      xfer_mode = m;
      tx_bits = t;
   endtask
   task automatic desel();
      h.sel(1'b0);
      h.drive(4'h0, IO_NONE);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks != 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // nibble 5 holds io3 low: must read as data, never as a pause
   task automatic t_quad_prog();
      cfg(1'b1, 8'h00, FPC_QUAD_PROG, 4'h0);
      h.sel(1'b1);
      foreach (nib[i]) begin
         n0 = n_rx;
         h.drive(nib[i], IO_ALL);
         h.pulse();
         chk(n_rx - n0, 12'h001, "quad prog count");
         chk(last_rx, nib[i], "quad prog nibble");
         chk(paused, 1'b0, "pause in quad mode");
      end
      desel();
   endtask
   task automatic t_quad_read();
      cfg(1'b1, 8'h00, FPC_QUAD_READ, 4'h6);
      h.sel(1'b1);
      h.drive(4'h0, IO_NONE);
      n0 = n_tx;
      h.pulse();
      chk(n_tx - n0, 12'h001, "quad read count");
      chk(last_tx, {IO_ALL, 4'h6}, "quad read nibble");
      desel();
   endtask
   // single-line read: only the serial output line is driven, from a fall
   task automatic t_sgl_rd();
      cfg(1'b0, 8'h00, FPC_SGL_RD, 4'h9);
      h.sel(1'b1);
      h.drive(4'h0, IO_NONE);
      n0 = n_tx;
      h.pulse();
      chk(n_tx - n0, 12'h001, "single read count");
      chk(last_tx, {IO_SO_ONLY, 4'h9}, "single read bits");
      desel();
   endtask
   task automatic t_pause();
      cfg(1'b0, 8'h00, FPC_SGL_WR, 4'h0);
      h.sel(1'b1);
      h.drive(4'h1, 4'h9);
      wait_cy(2);
      chk(paused, 1'b1, "pause not entered");
      chk(io_oe, IO_NONE, "output on in pause");
      n0 = n_rx;
      h.pulse();
      chk(n_rx - n0, 12'h000, "edge taken in pause");
      h.drive(4'h9, 4'h9);
      wait_cy(2);
      chk(paused, 1'b0, "pause not left");
      h.pulse();
      chk(n_rx - n0, 12'h001, "no resume");
      chk(last_rx, 4'h1, "resume data");
      desel();
   endtask
   task automatic t_reset_role();
      cfg(1'b0, 8'h80, FPC_SGL_WR, 4'h0);
      h.sel(1'b1);
      h.drive(4'h1, 4'h9);
      wait_cy(2);
      chk(pin_reset, 1'b1, "reset role");
      chk(paused, 1'b0, "pause in reset role");
      h.drive(4'h9, 4'h9);
      wait_cy(2);
      chk(pin_reset, 1'b0, "reset not released");
      desel();
   endtask
   // a second start and a pause land while busy; neither may change the length
   task automatic t_timed();
      cfg(1'b0, 8'h00, FPC_SGL_WR, 4'h0);
      n_busy = '0;
      timed_start = 1'b1;
      wait_cy(1);
      timed_start = 1'b0;
      h.sel(1'b1);
      h.drive(4'h1, 4'h9);
      wait_cy(50);
      timed_start = 1'b1;
      wait_cy(1);
      timed_start = 1'b0;
      wait_cy(260);
      chk(n_busy, TIMED_CYCLES, "timed length");
      desel();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      quad_enable_bit = 1'b0;
      timed_start = 1'b0;
      tx_bits = 4'h0;
      status3 = 8'h00;
      xfer_mode = FPC_IDLE;
      wait_cy(5);
      sys_rst = 1'b0;
      wait_cy(3);
      t_quad_prog();
      t_quad_read();
      t_sgl_rd();
      t_pause();
      t_reset_role();
      t_timed();
      test_done();
   end
   initial begin
      #200000;
      miscompares++;
      test_done();
   end
endmodule // fpc_top_tb
